// ==== include/idrs_pkg.sv ====
// Overview of operation
// R1 - activates spaced by row-to-row interval
// R2 - same bank waits for earlier precharge
// R3 - writes: 20-cycle row cycle, five banks
// R4 - reads: 16-cycle row cycle, four banks
// R5 - column packets spaced, two per activate
// R6 - column phase from activate-to-column delay
// R7 - column delay field shifts execution one cycle
// R8 - precharge spacing and phase after columns
// R9 - precharge delay field defers its execution
// R10 - page-empty: same packets, same relative slots
// R11 - two data packets, back-to-back data bus
// R12 - write data follows column by fixed delay
// R13 - read data follows column by fixed delay
// R14 - write-to-read turnaround before read column
// R15 - read-to-write turnaround before write column
// R16 - write-read bus gap from turnaround sum
// R17 - read-to-write turnaround formula with bubble
// R18 - data packet lasts one column cycle
// R19 - precharge no earlier than active time
// R20 - controller tracks per-bank precharge completion
package idrs_pkg;
	// ----------------------------------------------------------------
	// widths and geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int BANK_W = 3;
	localparam int NBANK = 8;
	localparam int ADDR_W = 4;
	localparam int MADDR_W = BANK_W + 2 * ADDR_W;
	localparam int RING = 32;
	localparam int RING_W = 5;
	localparam int DRING = 16;
	localparam int DRING_W = 4;
	localparam int WAIT_W = 6;
	// ----------------------------------------------------------------
	// link clock: clk cycles per half link period
	// ----------------------------------------------------------------
	localparam int LINK_HALF = 4;
	localparam int DIV_W = 2;
	// ----------------------------------------------------------------
	// timing in link cycles
	// ----------------------------------------------------------------
	localparam int ROW_TO_ROW = 4;
	localparam int COL_CYCLE = 2;
	localparam int ACT_TO_WRITE = 1;
	localparam int ACT_TO_READ = 5;
	localparam int WRITE_DATA_DELAY = 3;
	localparam int READ_DATA_DELAY = 6;
	localparam int WRITE_TO_PRE = 11;
	localparam int READ_TO_PRE = 3;
	localparam int PRE_TIME = 6;
	localparam int MIN_ACTIVE = 10;
	localparam int PRE_DLY_MAX = 3;
	localparam int WRITE_TO_READ = 9;
	localparam int READ_WRITE_BUS_GAP = 3;
	// turnaround for read then write
	localparam int READ_TO_WRITE = READ_DATA_DELAY - WRITE_DATA_DELAY + COL_CYCLE
		+ READ_WRITE_BUS_GAP;
	// resulting bus gap for write then read
	localparam int WRITE_READ_BUS_GAP = WRITE_TO_READ + READ_DATA_DELAY
		- WRITE_DATA_DELAY - COL_CYCLE;
	// ----------------------------------------------------------------
	// packets
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_NONE = 2'h0,
		KIND_ACT = 2'h1,
		KIND_COL = 2'h2,
		KIND_PRE = 2'h3
	} idrs_kind_t;
	typedef struct packed {
		idrs_kind_t kind;
		logic [1:0] dly;
		logic [BANK_W-1:0] bank;
		logic wr;
		logic [ADDR_W-1:0] addr;
	} idrs_pkt_t;
	typedef struct packed {
		logic wr;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [DATA_W-1:0] d0;
		logic [DATA_W-1:0] d1;
	} idrs_req_t;
	localparam idrs_pkt_t PKT_IDLE = '0;
endpackage : idrs_pkg

// ==== include/idrs_if.sv ====
// link between controller end and memory end
interface idrs_if;
	import idrs_pkg::*;
	logic link_clk;
	idrs_pkt_t request_bus;
	logic [DATA_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [DATA_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic [DATA_W-1:0] dq;
	// resolved data bus level, zero when nobody drives
	assign dq = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : '0);
	modport ctl (
		output link_clk,
		output request_bus,
		output ctl_dq_o,
		output ctl_dq_oe,
		input dq
	);
	modport dev (
		input link_clk,
		input request_bus,
		input dq,
		output dev_dq_o,
		output dev_dq_oe
	);
endinterface : idrs_if

// ==== src/idrs_dev.sv ====
// memory end: decodes request packets, runs banks, moves data
module idrs_dev (
	input logic clk,
	input logic rst_n,
	idrs_if.dev link,
	output logic [idrs_pkg::NBANK-1:0] bank_open,
	output logic access_error
);
	import idrs_pkg::*;

	typedef struct packed {
		logic ls1;
		logic ls2;
		logic ls3;
		idrs_pkt_t q1;
		idrs_pkt_t q2;
		logic [DATA_W-1:0] d1;
		logic [DATA_W-1:0] d2;
		logic [DRING_W-1:0] cyc;
		idrs_pkt_t [DRING-1:0] colq;
		logic [DRING-1:0] prev;
		logic [DRING-1:0][BANK_W-1:0] preb;
		logic [DRING-1:0] rdv;
		logic [DRING-1:0][DATA_W-1:0] rdd;
		logic [DRING-1:0] wrv;
		logic [DRING-1:0][MADDR_W-1:0] wra;
		logic [NBANK-1:0] open;
		logic [NBANK-1:0][ADDR_W-1:0] row;
		logic err;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe;
	} idrs_dev_st_t;

	idrs_dev_st_t r;
	idrs_dev_st_t next_r;
	logic [DATA_W-1:0] mem [2**MADDR_W];
	logic mem_we;
	logic [MADDR_W-1:0] mem_a;
	logic [MADDR_W-1:0] ca;
	logic [DRING_W-1:0] m;
	idrs_pkt_t pk;
	idrs_pkt_t ce;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		mem_we = 1'b0;
		mem_a = '0;
		ca = '0;
		m = r.cyc;
		pk = r.q2;
		ce = PKT_IDLE;
		// two-stage synchronisers for link clock, requests, data
		next_r.ls1 = link.link_clk;
		next_r.ls2 = r.ls1;
		next_r.ls3 = r.ls2;
		next_r.q1 = link.request_bus;
		next_r.q2 = r.q1;
		next_r.d1 = link.dq;
		next_r.d2 = r.d1;
		// rising link edge: new cycle, drive its read slot for one cycle
		if (r.ls2 && !r.ls3)
		begin
			m = DRING_W'(r.cyc + 1'b1);
			next_r.cyc = m;
			next_r.dq_o = r.rdd[m]; // see R11, see R18
			next_r.dq_oe = r.rdv[m];
			next_r.rdv[m] = 1'b0;
		end
		// falling link edge: request and write data are stable mid-cycle
		if (!r.ls2 && r.ls3)
		begin
			if (r.wrv[m])
			begin
				mem_we = 1'b1;
				mem_a = r.wra[m];
				next_r.wrv[m] = 1'b0;
			end
			if (pk.kind == KIND_ACT)
			begin
				next_r.open[pk.bank] = 1'b1;
				next_r.row[pk.bank] = pk.addr;
			end
			// deferred column from an earlier cycle
			if (r.colq[m].kind == KIND_COL)
			begin
				ce = r.colq[m];
				next_r.colq[m] = PKT_IDLE;
			end
			if (pk.kind == KIND_COL && pk.dly != 2'h0)
				next_r.colq[DRING_W'(m + 1'b1)] = pk; // see R7
			else if (pk.kind == KIND_COL)
				ce = pk;
			if (ce.kind == KIND_COL)
			begin
				if (!next_r.open[ce.bank])
					next_r.err = 1'b1;
				ca = {ce.bank, next_r.row[ce.bank], ce.addr};
				if (ce.wr)
				begin
					next_r.wrv[DRING_W'(m + WRITE_DATA_DELAY)] = 1'b1;
					next_r.wra[DRING_W'(m + WRITE_DATA_DELAY)] = ca;
				end
				else
				begin
					// read packet occupies the bus for a whole column cycle
					for (int k = 0; k < COL_CYCLE; k++)
					begin
						next_r.rdv[DRING_W'(m + READ_DATA_DELAY + k)] = 1'b1; // see R13, see R18
						next_r.rdd[DRING_W'(m + READ_DATA_DELAY + k)] = mem[ca]; // see R16
					end
				end
			end
			// precharge now or after its delay field
			if (r.prev[m])
			begin
				next_r.open[r.preb[m]] = 1'b0;
				next_r.prev[m] = 1'b0;
			end
			if (pk.kind == KIND_PRE && pk.dly == 2'h0)
				next_r.open[pk.bank] = 1'b0; // see R10
			else if (pk.kind == KIND_PRE)
			begin
				next_r.prev[DRING_W'(m + pk.dly)] = 1'b1; // see R9
				next_r.preb[DRING_W'(m + pk.dly)] = pk.bank;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	// array write, data taken from the synchronised bus
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_a] <= r.d2;
	end

	assign link.dev_dq_o = r.dq_o;
	assign link.dev_dq_oe = r.dq_oe;
	assign bank_open = r.open;
	assign access_error = r.err;
endmodule : idrs_dev

// ==== src/idrs_ctl.sv ====
// controller end: page-empty scheduler over a slot ring
module idrs_ctl (
	input logic clk,
	input logic rst_n,
	idrs_if.ctl link,
	input logic req_valid,
	output logic req_ready,
	input logic req_write,
	input logic [idrs_pkg::BANK_W-1:0] req_bank,
	input logic [idrs_pkg::ADDR_W-1:0] req_row,
	input logic [idrs_pkg::ADDR_W-1:0] req_col,
	input logic [idrs_pkg::DATA_W-1:0] req_wdata0,
	input logic [idrs_pkg::DATA_W-1:0] req_wdata1,
	output logic rsp_valid,
	output logic [idrs_pkg::DATA_W-1:0] rsp_data
);
	import idrs_pkg::*;

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic lclk;
		logic [RING_W-1:0] now;
		idrs_pkt_t [RING-1:0] rq;
		logic [RING-1:0] wv;
		logic [RING-1:0][DATA_W-1:0] wd;
		logic [RING-1:0] rx;
		logic [WAIT_W-1:0] act_w;
		logic [WAIT_W-1:0] col_w;
		logic [WAIT_W-1:0] w2r;
		logic [WAIT_W-1:0] r2w;
		logic [NBANK-1:0][WAIT_W-1:0] bank_w;
		idrs_req_t [1:0] fq;
		logic fhd;
		logic [1:0] fcnt;
		logic rdy;
		idrs_pkt_t rq_o;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe;
		logic [DATA_W-1:0] ds1;
		logic [DATA_W-1:0] ds2;
		logic rsp_v;
		logic [DATA_W-1:0] rsp_d;
	} idrs_ctl_st_t;

	idrs_ctl_st_t r;
	idrs_ctl_st_t next_r;
	idrs_pkt_t [RING-1:0] tb;
	idrs_req_t hd;
	logic [RING_W-1:0] cur;
	logic [WAIT_W-1:0] o0;
	logic [WAIT_W-1:0] oc;
	logic [WAIT_W-1:0] op;
	logic [WAIT_W-1:0] turn;
	logic tick;
	logic ok;
	logic done;
	logic push;
	logic pop;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [RING_W-1:0] ix(
		input logic [RING_W-1:0] b,
		input logic [WAIT_W-1:0] o
	);
		ix = RING_W'(b + o);
	endfunction : ix

	// countdown that rests at zero
	function automatic logic [WAIT_W-1:0] dec(input logic [WAIT_W-1:0] w);
		dec = (w == '0) ? '0 : WAIT_W'(w - 1'b1);
	endfunction : dec

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		tb = r.rq;
		hd = r.fq[r.fhd];
		cur = RING_W'(r.now + 1'b1);
		o0 = '0;
		oc = '0;
		op = '0;
		turn = '0;
		ok = 1'b0;
		done = 1'b0;
		pop = 1'b0;
		push = req_valid && r.rdy;
		tick = (r.div == DIV_W'(LINK_HALF - 1)) && !r.lclk;
		next_r.ds1 = link.dq;
		next_r.ds2 = r.ds1;
		next_r.rsp_v = 1'b0;
		// link clock divider, this end owns the link clock
		if (r.div == DIV_W'(LINK_HALF - 1))
		begin
			next_r.div = '0;
			next_r.lclk = !r.lclk;
		end
		else
			next_r.div = DIV_W'(r.div + 1'b1);
		// start of a link cycle: emit slot, drive data, catch read data
		if (tick)
		begin
			next_r.now = cur;
			next_r.rq_o = r.rq[cur];
			next_r.rq[cur] = PKT_IDLE;
			next_r.dq_o = r.wd[cur]; // see R12
			next_r.dq_oe = r.wv[cur];
			next_r.wv[cur] = 1'b0;
			if (r.rx[cur])
			begin
				next_r.rsp_v = 1'b1;
				next_r.rsp_d = r.ds2;
				next_r.rx[cur] = 1'b0;
			end
			next_r.act_w = dec(r.act_w);
			next_r.col_w = dec(r.col_w);
			next_r.w2r = dec(r.w2r);
			next_r.r2w = dec(r.r2w);
			for (int b = 0; b < NBANK; b++)
				next_r.bank_w[b] = dec(r.bank_w[b]);
			// try to open the next transaction in this slot
			if (r.fcnt != 2'h0 && r.rq[cur].kind == KIND_NONE
				&& next_r.act_w == '0 && next_r.bank_w[hd.bank] == '0) // see R1, see R2
			begin
				o0 = hd.wr ? WAIT_W'(ACT_TO_WRITE) : WAIT_W'(ACT_TO_READ); // see R6
				turn = hd.wr ? next_r.r2w : next_r.w2r; // see R14, see R15
				ok = (next_r.col_w <= o0) && (turn <= o0);
				tb = next_r.rq;
				tb[cur] = '{KIND_ACT, 2'h0, hd.bank, 1'b0, hd.row};
				// two columns, pulled one slot early when taken
				for (int k = 0; k < 2; k++)
				begin
					oc = WAIT_W'(o0 + k * COL_CYCLE); // see R5
					if (tb[ix(cur, oc)].kind == KIND_NONE)
						tb[ix(cur, oc)] = '{KIND_COL, 2'h0, hd.bank, hd.wr, hd.col};
					else if (tb[ix(cur, WAIT_W'(oc - 1'b1))].kind == KIND_NONE)
						tb[ix(cur, WAIT_W'(oc - 1'b1))] = '{KIND_COL, 2'h1, hd.bank,
							hd.wr, hd.col}; // see R7
					else
						ok = 1'b0;
				end
				// precharge at the later of column-based and active-time bound
				op = WAIT_W'(oc + (hd.wr ? WRITE_TO_PRE : READ_TO_PRE)); // see R8
				if (op < WAIT_W'(MIN_ACTIVE))
					op = WAIT_W'(MIN_ACTIVE); // see R19
				for (int d = 0; d <= PRE_DLY_MAX; d++)
				begin
					if (!done && tb[ix(cur, WAIT_W'(op - d))].kind == KIND_NONE)
					begin
						tb[ix(cur, WAIT_W'(op - d))] = '{KIND_PRE, 2'(d), hd.bank,
							1'b0, hd.col}; // see R9
						done = 1'b1;
					end
				end
				if (ok && done)
				begin
					pop = 1'b1;
					next_r.rq = tb; // see R10
					next_r.rq_o = tb[cur];
					next_r.rq[cur] = PKT_IDLE;
					for (int k = 0; k < 2; k++)
					begin
						oc = WAIT_W'(o0 + k * COL_CYCLE);
						if (hd.wr)
						begin
							// each write packet fills a whole column cycle
							for (int j = 0; j < COL_CYCLE; j++)
							begin
								next_r.wv[ix(cur, WAIT_W'(oc + WRITE_DATA_DELAY + j))] = 1'b1;
								next_r.wd[ix(cur, WAIT_W'(oc + WRITE_DATA_DELAY + j))] =
									(k == 0) ? hd.d0 : hd.d1; // see R11
							end
						end
						else
							next_r.rx[ix(cur, WAIT_W'(oc + READ_DATA_DELAY + 1))] = 1'b1;
					end
					next_r.act_w = WAIT_W'(ROW_TO_ROW);
					next_r.col_w = WAIT_W'(oc + COL_CYCLE);
					// bank busy until its precharge completes
					next_r.bank_w[hd.bank] = WAIT_W'(op + PRE_TIME); // see R20, see R3, see R4
					if (hd.wr)
						next_r.w2r = WAIT_W'(oc + WRITE_TO_READ); // see R14
					else
						next_r.r2w = WAIT_W'(oc + READ_TO_WRITE); // see R15, see R17
				end
			end
		end
		// two-entry request buffer
		if (pop)
			next_r.fhd = !r.fhd;
		if (push)
			next_r.fq[r.fhd ^ r.fcnt[0]] = '{req_write, req_bank, req_row, req_col,
				req_wdata0, req_wdata1};
		next_r.fcnt = 2'(r.fcnt + push - pop);
		next_r.rdy = (next_r.fcnt != 2'h2);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	// outputs straight from state
	assign link.link_clk = r.lclk;
	assign link.request_bus = r.rq_o;
	assign link.ctl_dq_o = r.dq_o;
	assign link.ctl_dq_oe = r.dq_oe;
	assign req_ready = r.rdy;
	assign rsp_valid = r.rsp_v;
	assign rsp_data = r.rsp_d;
endmodule : idrs_ctl

// ==== bench/idrs_properties.sv ====
module idrs_properties (
	input logic clk,
	input logic rst_n,
	input logic link_clk,
	input idrs_pkg::idrs_pkt_t request_bus,
	input logic ctl_dq_oe,
	input logic dev_dq_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import idrs_pkg::*;
	logic lk_q;
	logic lr;
	logic act;
	logic wcol;
	logic rcol;
	logic [6:0] w_age;
	logic [6:0] r_age;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------
	// link rise and packet decode
	// ------------------------------------------------
	assign lr = link_clk & ~lk_q;
	assign act = lr && request_bus.kind == KIND_ACT;
	assign wcol = lr && request_bus.kind == KIND_COL && request_bus.wr;
	assign rcol = lr && request_bus.kind == KIND_COL && !request_bus.wr;
	// clk cycles since the last column of each kind, saturating
	always_ff @(posedge clk)
	begin
		lk_q <= link_clk;
		if (!rst_n || (w_age == 7'h7f && !wcol))
			w_age <= 7'h7f;
		else
			w_age <= wcol ? 7'h01 : w_age + 7'h01;
		if (!rst_n || (r_age == 7'h7f && !rcol))
			r_age <= 7'h7f;
		else
			r_age <= rcol ? 7'h01 : r_age + 7'h01;
	end
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	property p_bus_hold;
		!lr |-> $stable(request_bus);
	endproperty
	a_bus_hold: assert property (p_bus_hold)
		else $error("request bus changed between link rises");
	property p_act_gap;
		act |-> ##8 !act ##8 !act ##8 !act;
	endproperty
	a_act_gap: assert property (p_act_gap)
		else $error("activates closer than four link cycles");
	property p_wdata;
		wcol && request_bus.dly == 2'h0 |-> ##24 ctl_dq_oe [*8] ##1 ctl_dq_oe [*8];
	endproperty
	a_wdata: assert property (p_wdata)
		else $error("write data not held a column cycle from three link cycles after column");
	property p_rdata;
		rcol && request_bus.dly == 2'h0 |-> ##52 dev_dq_oe;
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data missing six link cycles after column");
	property p_rdata_late;
		rcol && request_bus.dly == 2'h1 |-> ##60 dev_dq_oe;
	endproperty
	a_rdata_late: assert property (p_rdata_late)
		else $error("delayed read column not shifted by one link cycle");
	property p_dq_len;
		$rose(dev_dq_oe) |-> dev_dq_oe [*8] ##1 dev_dq_oe [*8];
	endproperty
	a_dq_len: assert property (p_dq_len)
		else $error("read data packet shorter than one column cycle");
	property p_one_driver;
		!(ctl_dq_oe && dev_dq_oe);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive the data bus");
	property p_wr_to_rd;
		rcol |-> int'(w_age) + 8 * int'(request_bus.dly) >= 72;
	endproperty
	a_wr_to_rd: assert property (p_wr_to_rd)
		else $error("read column too soon after write column");
	property p_rd_to_wr;
		wcol |-> int'(r_age) >= 64;
	endproperty
	a_rd_to_wr: assert property (p_rd_to_wr)
		else $error("write column too soon after read column");
	c_write: cover property (wcol);
	c_read: cover property (rcol);
	c_rd_after_wr: cover property (rcol && w_age < 7'h7f);
endmodule : idrs_properties

// ==== bench/idrs_bench.sv ====
module idrs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import idrs_pkg::*;
	logic clk;
	logic rst_n;
	logic req_valid;
	logic req_ready;
	logic req_write;
	logic [BANK_W-1:0] req_bank;
	logic [ADDR_W-1:0] req_row;
	logic [ADDR_W-1:0] req_col;
	logic [DATA_W-1:0] req_wdata0;
	logic [DATA_W-1:0] req_wdata1;
	logic rsp_valid;
	logic [DATA_W-1:0] rsp_data;
	logic [NBANK-1:0] bank_open;
	logic access_error;
	logic access_error_2;
	logic [NBANK-1:0] bank_open_2;
	logic lk_q;
	logic [DATA_W-1:0] exp_q[$];
	logic [DATA_W-1:0] got_q[$];
	int error_cnt;
	int check_count;
	int acts;
	int cols;
	int n_req;
	int stalls;
	idrs_if link();
	idrs_if link_f();
	// ------------------------------------------------
	// design ends and checker
	// ------------------------------------------------
	idrs_ctl i_idrs_ctl (.clk(clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
		.req_col(req_col), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	idrs_dev i_idrs_dev (.clk(clk), .rst_n(rst_n), .link(link), .bank_open(bank_open),
		.access_error(access_error));
	// second memory end, driven by a misbehaving controller
	idrs_dev i_idrs_dev_2 (.clk(clk), .rst_n(rst_n), .link(link_f), .bank_open(bank_open_2),
		.access_error(access_error_2));
	idrs_properties i_idrs_properties (.clk(clk), .rst_n(rst_n), .link_clk(link.link_clk),
		.request_bus(link.request_bus), .ctl_dq_oe(link.ctl_dq_oe),
		.dev_dq_oe(link.dev_dq_oe));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// read words and packet counts
	always @(posedge clk)
	begin
		lk_q <= link.link_clk;
		if (rsp_valid === 1'b1)
			got_q.push_back(rsp_data);
		if (link.link_clk && !lk_q && link.request_bus.kind == KIND_ACT)
			acts++;
		if (link.link_clk && !lk_q && link.request_bus.kind == KIND_COL)
			cols++;
	end
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic end_sim;
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	// offer one request; a read expects word d1 twice, both columns share one address
	task automatic send(input logic w, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] r, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= w;
		req_bank <= b;
		req_row <= r;
		req_col <= r + 4'h3;
		req_wdata0 <= d0;
		req_wdata1 <= d1;
		@(posedge clk);
		while (req_ready !== 1'b1)
		begin
			n++;
			stalls++;
			if (n > 500)
			begin
				check(32'h0, 32'h1);
				end_sim();
			end
			@(posedge clk);
		end
		n_req++;
		if (!w)
		begin
			exp_q.push_back(d1);
			exp_q.push_back(d1);
		end
	endtask : send
	// let traffic finish, then judge returned words and bus counts
	task automatic drain;
		int n;
		n = 0;
		req_valid <= 1'b0;
		@(posedge clk);
		while (got_q.size() < exp_q.size() || n < 400)
		begin
			n++;
			if (n > 4000)
			begin
				check(32'h0, 32'h1);
				end_sim();
			end
			@(posedge clk);
		end
		check(got_q.size(), exp_q.size());
		while (exp_q.size() > 0 && got_q.size() > 0)
			check(got_q.pop_front(), exp_q.pop_front());
		check(acts, n_req);
		check(cols, 2 * n_req);
		check(access_error, 1'b0);
		check(bank_open, 32'h0);
	endtask : drain
	// write then read of the same bank, back to back
	task automatic t_write_read;
		send(1'b1, 3'h0, 4'h1, 16'h1111, 16'ha5c3);
		send(1'b0, 3'h0, 4'h1, 16'h0, 16'ha5c3);
		drain();
	endtask : t_write_read
	// five-bank write stream, four banks read back, buffer must refuse meanwhile
	task automatic t_stream;
		stalls = 0;
		for (int i = 0; i < 5; i++)
			send(1'b1, 3'(i + 1), 4'(i), 16'h2000, 16'h3c00 + 16'(i));
		check(stalls > 0, 1'b1);
		for (int i = 0; i < 4; i++)
			send(1'b0, 3'(i + 1), 4'(i), 16'h0, 16'h3c00 + 16'(i));
		send(1'b1, 3'h6, 4'h9, 16'h0, 16'h5a5a);
		send(1'b0, 3'h6, 4'h9, 16'h0, 16'h5a5a);
		drain();
	endtask : t_stream
	// same bank twice, different rows
	task automatic t_same_bank;
		send(1'b1, 3'h7, 4'h2, 16'h0, 16'h7001);
		send(1'b1, 3'h7, 4'h5, 16'h0, 16'h7002);
		send(1'b0, 3'h7, 4'h2, 16'h0, 16'h7001);
		send(1'b0, 3'h7, 4'h5, 16'h0, 16'h7002);
		drain();
	endtask : t_same_bank
	// one link cycle on the second link carrying one packet
	task automatic f_cycle(input idrs_pkt_t p);
		link_f.request_bus <= p;
		link_f.link_clk <= 1'b1;
		repeat (4) @(posedge clk);
		link_f.link_clk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : f_cycle
	// column to a closed bank, then a precharge held back by its delay field
	task automatic t_closed_col;
		f_cycle(idrs_pkt_t'{kind: KIND_COL, dly: 2'h0, bank: 3'h2, wr: 1'b0, addr: 4'h1});
		repeat (3) f_cycle(PKT_IDLE);
		check(access_error_2, 1'b1);
		f_cycle(idrs_pkt_t'{kind: KIND_ACT, dly: 2'h0, bank: 3'h2, wr: 1'b0, addr: 4'h1});
		f_cycle(idrs_pkt_t'{kind: KIND_PRE, dly: 2'h2, bank: 3'h2, wr: 1'b0, addr: 4'h0});
		f_cycle(PKT_IDLE);
		check(bank_open_2[2], 1'b1);
		f_cycle(PKT_IDLE);
		check(bank_open_2[2], 1'b0);
	endtask : t_closed_col
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_bank = '0;
		req_row = '0;
		req_col = '0;
		req_wdata0 = '0;
		req_wdata1 = '0;
		link_f.link_clk = 1'b0;
		link_f.request_bus = PKT_IDLE;
		link_f.ctl_dq_o = '0;
		link_f.ctl_dq_oe = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_write_read();
		t_stream();
		t_same_bank();
		t_closed_col();
		end_sim();
	end
endmodule : idrs_bench
